// File: design/vsf_regs.vh
// register offsets, field positions, reset values and timing for the status frame block
`ifndef VSF_REGS_VH
`define VSF_REGS_VH

// register byte offsets
`define VSF_CTRL        12'h000
`define VSF_NODE        12'h004
`define VSF_ALARM_THR   12'h008
`define VSF_SHUT_THR    12'h00c
`define VSF_WORD9       12'h010
`define VSF_WORD10      12'h014
`define VSF_WORD8       12'h018
`define VSF_IRQ_STAT    12'h01c
`define VSF_IRQ_MASK    12'h020
`define VSF_FRAME_ID    12'h024
`define VSF_STATUS      12'h028
`define VSF_FRAME_CNT   12'h02c
`define VSF_MISS_CNT    12'h030
`define VSF_LAST_W8     12'h034

// control fields
`define VSF_CTRL_EN     0
`define VSF_CTRL_RST    32'h0000_0001

// interrupt status fields
`define VSF_IRQ_SENT    0
`define VSF_IRQ_FLAG    1
`define VSF_IRQ_MISSED  2

// word eight flag positions
`define VSF_B_AUTODET   0
`define VSF_B_NOMOD     1
`define VSF_B_SERIAL    2
`define VSF_B_POWER     3
`define VSF_B_NEWTYPE   4
`define VSF_B_RES_ALARM 5
`define VSF_B_RES_SHUT  6
`define VSF_FLAG_BITS   7

// frame constants
`define VSF_ID_BASE     11'h4e0
`define VSF_DLC         4'h6
`define VSF_RX_TRIGGER  2

// delay from trigger to frame
`define VSF_DELAY_US    12000
`define VSF_CLK_MHZ     100
`define VSF_DELAY_CYC   (`VSF_DELAY_US * `VSF_CLK_MHZ)

// reset values of the thresholds
`define VSF_ALARM_RST   16'h0100
`define VSF_SHUT_RST    16'h0400

`endif

// File: design/vsf_frame.v
// status flag frame builder with apb registers and delayed can transmit
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "vsf_regs.vh"

module vsf_frame #(
    parameter DELAY_CYC = `VSF_DELAY_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rx_pdo_valid,
    input  wire [3:0]  rx_pdo_num,
    input  wire        idmod_comm_fail,
    input  wire        idmod_read_fail,
    input  wire        serial_mismatch,
    input  wire        power_board_bad,
    input  wire        type_unsupported,
    input  wire [15:0] resolver_a,
    input  wire [15:0] resolver_b,
    output reg         tx_valid,
    input  wire        tx_ready,
    output reg  [10:0] tx_id,
    output reg  [3:0]  tx_dlc,
    output reg  [47:0] tx_data,
    output wire        irq
);

    // register state
    reg         enable;
    reg  [6:0]  node_id;
    reg  [15:0] alarm_thr;
    reg  [15:0] shut_thr;
    reg  [15:0] word9;
    reg  [15:0] word10;
    wire [15:0] word8;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    reg  [31:0] delay_cnt;
    reg         waiting;
    reg  [1:0]  state;
    reg  [15:0] frame_cnt;
    reg  [15:0] miss_cnt;
    reg  [15:0] last_word8;
    reg  [31:0] rd_mux;

    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_SEND = 2'b10;

    wire        wr_en = psel & penable & pwrite;
    wire [15:0] res_diff;
    wire        res_alarm;
    wire        res_shut;
    wire        trigger;
    wire [15:0] next_word8;
    wire [2:0]  ev;
    wire        frame_done;
    wire [6:0]  flag_bus;
    wire [6:0]  flag_rise;

    // apb answers without wait states, unmapped reads give zero
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // absolute resolver difference and its two threshold compares
    assign res_diff  = (resolver_a > resolver_b) ? (resolver_a - resolver_b)
                                                 : (resolver_b - resolver_a);
    assign res_alarm = (res_diff > alarm_thr);
    assign res_shut  = (res_diff > shut_thr);

    // live word eight, upper bits zero
    assign next_word8 = {9'h000,
                         res_shut,
                         res_alarm,
                         type_unsupported,
                         power_board_bad,
                         serial_mismatch,
                         idmod_read_fail,
                         idmod_comm_fail};

    // second receive pdo starts the delay
    assign trigger    = enable & rx_pdo_valid & (rx_pdo_num == `VSF_RX_TRIGGER);
    assign frame_done = (state == ST_SEND) & tx_valid & tx_ready;

    // events: frame sent, any flag raised, trigger while busy
    assign ev = {trigger & (state != ST_IDLE),
                 |flag_rise,
                 frame_done};

    assign irq = |(irq_stat & irq_mask);

    // per flag bit: one-cycle sample and fresh-rise detect
    genvar gi;
    generate
        for (gi = 0; gi < `VSF_FLAG_BITS; gi = gi + 1) begin : g_flag
            reg flag_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_q <= 1'b0;
                end else begin
                    flag_q <= next_word8[gi];
                end
            end
            assign flag_bus[gi]  = flag_q;
            assign flag_rise[gi] = next_word8[gi] & ~flag_q;
        end
    endgenerate

    // undefined upper bits of word eight stay zero
    assign word8 = {9'h000, flag_bus};

    // frames sent and triggers refused, both saturate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt  <= 16'h0000;
            miss_cnt   <= 16'h0000;
            last_word8 <= 16'h0000;
        end else begin
            if (frame_done && frame_cnt != 16'hffff) begin
                frame_cnt <= frame_cnt + 16'h0001;
            end
            if (ev[2] && miss_cnt != 16'hffff) begin
                miss_cnt <= miss_cnt + 16'h0001;
            end
            // copy of the flags that last left the block
            if (frame_done) begin
                last_word8 <= tx_data[15:0];
            end
        end
    end

    // register writes and sticky interrupt status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable    <= 1'b1;
            node_id   <= 7'h00;
            alarm_thr <= `VSF_ALARM_RST;
            shut_thr  <= `VSF_SHUT_RST;
            word9     <= 16'h0000;
            word10    <= 16'h0000;
            irq_stat  <= 3'h0;
            irq_mask  <= 3'h0;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `VSF_CTRL:      enable    <= pwdata[`VSF_CTRL_EN];
                    `VSF_NODE:      node_id   <= pwdata[6:0];
                    `VSF_ALARM_THR: alarm_thr <= pwdata[15:0];
                    `VSF_SHUT_THR:  shut_thr  <= pwdata[15:0];
                    `VSF_WORD9:     word9     <= pwdata[15:0];
                    `VSF_WORD10:    word10    <= pwdata[15:0];
                    `VSF_IRQ_MASK:  irq_mask  <= pwdata[2:0];
                    default: ;
                endcase
            end
            // set wins over write-one-clear
            if (wr_en && paddr == `VSF_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[2:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
        end
    end

    // read mux
    always @* begin
        case (paddr)
            `VSF_CTRL:      rd_mux = {31'h0, enable};
            `VSF_NODE:      rd_mux = {25'h0, node_id};
            `VSF_ALARM_THR: rd_mux = {16'h0, alarm_thr};
            `VSF_SHUT_THR:  rd_mux = {16'h0, shut_thr};
            `VSF_WORD9:     rd_mux = {16'h0, word9};
            `VSF_WORD10:    rd_mux = {16'h0, word10};
            `VSF_WORD8:     rd_mux = {16'h0, word8};
            `VSF_IRQ_STAT:  rd_mux = {29'h0, irq_stat};
            `VSF_IRQ_MASK:  rd_mux = {29'h0, irq_mask};
            `VSF_FRAME_ID:  rd_mux = {21'h0, `VSF_ID_BASE + {4'h0, node_id}};
            `VSF_STATUS:    rd_mux = {29'h0, waiting, state};
            `VSF_FRAME_CNT: rd_mux = {16'h0, frame_cnt};
            `VSF_MISS_CNT:  rd_mux = {16'h0, miss_cnt};
            `VSF_LAST_W8:   rd_mux = {16'h0, last_word8};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in setup, stands through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // delay counter and frame sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            delay_cnt <= 32'h0;
            waiting   <= 1'b0;
            tx_valid  <= 1'b0;
            tx_id     <= 11'h000;
            tx_dlc    <= 4'h0;
            tx_data   <= 48'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (trigger) begin
                        delay_cnt <= 32'h1;
                        state     <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (delay_cnt >= DELAY_CYC) begin
                        state    <= ST_SEND;
                        tx_valid <= 1'b1;
                        tx_id    <= `VSF_ID_BASE + {4'h0, node_id};
                        tx_dlc   <= `VSF_DLC;
                        // low byte first per word, words 8, 9, 10
                        tx_data  <= {word10[15:8], word10[7:0],
                                     word9[15:8], word9[7:0],
                                     word8[15:8], word8[7:0]};
                    end else begin
                        delay_cnt <= delay_cnt + 32'h1;
                    end
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        state    <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            waiting <= (state == ST_WAIT);
        end
    end

endmodule // vsf_frame

// File: dv/vsf_frame_monitor.sv
// assertions on the status frame outputs
`timescale 1ns/100ps
module vsf_frame_monitor #(parameter D = 20) (
    input wire        pclk,
    input wire        presetn,
    input wire        rx_pdo_valid,
    input wire [3:0]  rx_pdo_num,
    input wire        idmod_comm_fail,
    input wire        idmod_read_fail,
    input wire        serial_mismatch,
    input wire        power_board_bad,
    input wire        type_unsupported,
    input wire        tx_valid,
    input wire        tx_ready,
    input wire [10:0] tx_id,
    input wire [3:0]  tx_dlc,
    input wire [47:0] tx_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // trigger and live flag vector
    wire       trig = rx_pdo_valid && rx_pdo_num == 4'h2;
    wire [4:0] fl = {type_unsupported, power_board_bad, serial_mismatch, idmod_read_fail,
                     idmod_comm_fail};
    sequence s_offer; tx_valid && !tx_ready; endsequence
    sequence s_take; tx_valid && tx_ready; endsequence
    property p_delay; $rose(tx_valid) |-> $past(trig, D + 1); endproperty
    property p_wait; trig && !tx_valid |=> !tx_valid [*8]; endproperty
    property p_hold; s_offer |=> tx_valid && $stable({tx_id, tx_dlc, tx_data}); endproperty
    property p_drop; s_take |=> !tx_valid; endproperty
    property p_dlc; tx_valid |-> tx_dlc == 4'h6; endproperty
    property p_id; tx_valid |-> tx_id >= 11'h4e0 && tx_id <= 11'h55f; endproperty
    property p_zero; tx_valid |-> tx_data[15:7] == 9'h0; endproperty
    property p_flags;
        $rose(tx_valid) && $past(fl) == $past(fl, 3) && $past(fl, 2) == $past(fl, 3)
            |-> tx_data[4:0] == $past(fl, 2);
    endproperty
    a_delay: assert property (p_delay) else $error("frame not at trigger delay");
    a_wait: assert property (p_wait) else $error("frame sent early");
    a_hold: assert property (p_hold) else $error("frame changed while offered");
    a_drop: assert property (p_drop) else $error("frame kept after accept");
    a_dlc: assert property (p_dlc) else $error("wrong length");
    a_id: assert property (p_id) else $error("identifier out of range");
    a_zero: assert property (p_zero) else $error("undefined bits not zero");
    a_flags: assert property (p_flags) else $error("flag bits wrong");
endmodule // vsf_frame_monitor
bind vsf_frame vsf_frame_monitor #(.D(DELAY_CYC)) u_mon (.pclk(pclk), .presetn(presetn),
    .rx_pdo_valid(rx_pdo_valid), .rx_pdo_num(rx_pdo_num), .idmod_comm_fail(idmod_comm_fail),
    .idmod_read_fail(idmod_read_fail), .serial_mismatch(serial_mismatch),
    .power_board_bad(power_board_bad), .type_unsupported(type_unsupported),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));

// File: dv/vsf_can_master.sv
// network master model: sends receive messages, accepts frames
`timescale 1ns/100ps
module vsf_can_master (
    input  wire logic pclk,
    input  wire logic tx_valid,
    output logic      rx_pdo_valid,
    output logic [3:0] rx_pdo_num,
    output logic      tx_ready
);
    int stall = 0;
    int n = 0;
    initial begin
        rx_pdo_valid = 0;
        rx_pdo_num = 4'h5;
        tx_ready = 0;
    end
    // one message pulse, number inverted once released
    task send(input logic [3:0] k);
        @(posedge pclk);
        rx_pdo_valid <= 1;
        rx_pdo_num <= k;
        @(posedge pclk);
        rx_pdo_valid <= 0;
        rx_pdo_num <= ~k;
    endtask
    // accept an offered frame after stall cycles
    always @(posedge pclk) begin
        tx_ready <= 0;
        if (tx_valid && !tx_ready) begin
            n <= (n >= stall) ? 0 : n + 1;
            tx_ready <= n >= stall;
        end
    end
endmodule // vsf_can_master

// File: dv/valve_status_flag_frame_tb.sv
// self-checking bench for the status frame block
`timescale 1ns/100ps
`include "vsf_regs.vh"
module valve_status_flag_frame_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, rx_pdo_valid, tx_ready, tx_valid, irq;
    logic [3:0]  rx_pdo_num, tx_dlc;
    logic [4:0]  fl = 0;
    logic [15:0] ra = 0, rb = 0, d, b, w8, w9, w10;
    logic [10:0] tx_id, id;
    logic [47:0] tx_data;
    logic [62:0] q[$];
    int          mismatches = 0, compares = 0;
    always #5 pclk = ~pclk;
    vsf_frame #(.DELAY_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pdo_valid(rx_pdo_valid),
        .rx_pdo_num(rx_pdo_num), .idmod_comm_fail(fl[0]), .idmod_read_fail(fl[1]),
        .serial_mismatch(fl[2]), .power_board_bad(fl[3]), .type_unsupported(fl[4]),
        .resolver_a(ra), .resolver_b(rb), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .irq(irq));
    vsf_can_master m (.pclk(pclk), .tx_valid(tx_valid), .rx_pdo_valid(rx_pdo_valid),
        .rx_pdo_num(rx_pdo_num), .tx_ready(tx_ready));
    task chk(input string n, input logic [62:0] e, input logic [62:0] s);
        compares++;
        if (e !== s) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", pslverr, 0);
        psel <= 0;
        penable <= 0;
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // compare each accepted frame with the oldest note
    always @(posedge pclk)
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            chk("frame", q.size() ? q.pop_front() : 63'h0, {tx_id, tx_dlc, tx_data});
    initial begin
        rd = $urandom(32'h1b88d16c);
        repeat (2) @(posedge pclk);
        presetn <= 1;
        id = 11'h4e0 + 11'($urandom % 128);
        w9 = 16'($urandom);
        w10 = 16'($urandom);
        apb(1, `VSF_NODE, 32'(id - 11'h4e0));
        apb(1, `VSF_WORD9, 32'(w9));
        apb(1, `VSF_WORD10, 32'(w10));
        apb(1, `VSF_IRQ_MASK, 32'h7);
        for (int i = 0; i < 4; i++) begin
            d = (i[1] ? `VSF_SHUT_RST : `VSF_ALARM_RST) + 16'(i[0]);
            b = 16'($urandom) & 16'h7fff;
            fl <= 5'($urandom);
            ra <= i[0] ? b + d : b;
            rb <= i[0] ? b : b + d;
            m.stall = i;
            repeat (3) @(posedge pclk);
            w8 = {11'h0, fl};
            w8[6:5] = {d > `VSF_SHUT_RST, d > `VSF_ALARM_RST};
            q.push_back({id, `VSF_DLC, w10, w9, w8});
            m.send(4'h1);
            m.send(4'h2);
            m.send(4'h2);
            for (int k = 0; k < 100 && q.size() > 0; k++) @(posedge pclk);
            $display("frame test %0d done", i);
        end
        apb(0, `VSF_WORD8, 0);
        chk("word8", rd, w8);
        apb(0, `VSF_LAST_W8, 0);
        chk("last word8", rd, w8);
        apb(0, `VSF_FRAME_CNT, 0);
        chk("frame count", rd, 4);
        apb(0, `VSF_MISS_CNT, 0);
        chk("refused count", rd, 4);
        chk("irq", irq, 1);
        apb(0, `VSF_IRQ_STAT, 0);
        chk("irq status", rd & 5, 5);
        apb(1, `VSF_IRQ_STAT, 7);
        @(posedge pclk);
        chk("irq clear", irq, 0);
        apb(0, 12'h0fc, 0);
        chk("unmapped", rd, 0);
        apb(0, `VSF_FRAME_ID, 0);
        chk("frame id", rd, id);
        apb(1, `VSF_CTRL, 0);
        m.send(4'h2);
        repeat (30) @(posedge pclk);
        apb(0, `VSF_STATUS, 0);
        chk("no frame when off", rd, 0);
        apb(1, `VSF_CTRL, 1);
        $display("register test done");
        finish_test;
    end
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end
endmodule // valve_status_flag_frame_tb
